// >>> hdl/rcff_regulator_control.sv
// rcff_regulator_control: rail enables, fault shutdown, fault flags,
// strap latch and interrupt pulse for the supply rails.
// assumes fault comparators and straps are asynchronous pins; sw strobes
// come from the serial interface logic on clk_i.
`timescale 1ns/1ps
`default_nettype none
module rcff_regulator_control #(
    parameter int unsigned INT_LONG_CYC = rcff_pkg::RCFF_INT_LONG_CYC,
    parameter int unsigned INT_SHORT_CYC = rcff_pkg::RCFF_INT_SHORT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // configuration read request: power-on release or low-power wake
    input wire logic cfg_read_i,
    input wire logic [2:0] select_code_i,
    input wire logic boost_gate_drive_sense_i,
    input wire logic ext_pass_transistor_i,
    // fault comparator pins
    input wire logic core_ov_i,
    input wire logic ana_ov_i,
    input wire logic ana_oc_i,
    input wire logic aux_ov_i,
    input wire logic aux_oc_i,
    // software commands, one-cycle strobes except the init_phase_i level
    input wire logic core_on_i,
    input wire logic core_off_i,
    input wire logic ana_on_i,
    input wire logic ana_off_i,
    input wire logic aux_on_i,
    input wire logic aux_off_i,
    input wire logic flag_clr_i,
    input wire logic init_phase_i,
    input wire logic int_cfg_wr_i,
    input wire logic int_cfg_long_i,
    input wire logic int_cfg_en_i,
    output logic preregulator_rail_en_o,
    output logic core_supply_rail_en_o,
    output logic analog_reference_rail_en_o,
    output logic auxiliary_rail_en_o,
    output logic transceiver_supply_rail_en_o,
    output logic buck_boost_mode_o,
    output logic [1:0] voltage_pair_o,
    output logic deep_fs_main_o,
    output logic deep_fs_safe_o,
    output logic [1:0] core_ana_flags_o,
    output logic [1:0] ana_flags_o,
    output logic [1:0] aux_flags_o,
    output logic interrupt_pulse_out_n_o
);
    import rcff_pkg::*;

    // two-flop synchronisers for all asynchronous pins
    // the select code must settle before the config request rises, since
    // its bits pass the flops separately and could skew by a cycle
    localparam int unsigned NSYNC = RCFF_NFLT + 5;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    assign pin_raw = {boost_gate_drive_sense_i, select_code_i, cfg_read_i,
                      aux_oc_i, aux_ov_i, ana_oc_i, ana_ov_i, core_ov_i};
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else if (clk_en_i) begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    wire logic [RCFF_NFLT-1:0] flt_lvl;
    wire logic cfg_lvl;
    wire logic [2:0] sel_s;
    wire logic gate_s;
    assign flt_lvl = sync2_r[RCFF_NFLT-1:0];
    assign cfg_lvl = sync2_r[RCFF_NFLT];
    assign sel_s = sync2_r[RCFF_NFLT+3:RCFF_NFLT+1];
    assign gate_s = sync2_r[RCFF_NFLT+4];

    // rising edges of fault levels and config request
    // edge flops reset low like the idle pins, so no false edge after reset
    logic [RCFF_NFLT-1:0] flt_prev_r;
    logic cfg_prev_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flt_prev_r <= '0;
            cfg_prev_r <= 1'b0;
        end else if (clk_en_i) begin
            flt_prev_r <= flt_lvl;
            cfg_prev_r <= cfg_lvl;
        end
    end
    wire logic [RCFF_NFLT-1:0] flt_rise;
    wire logic cfg_take;
    assign flt_rise = flt_lvl & ~flt_prev_r;
    assign cfg_take = cfg_lvl & ~cfg_prev_r;

    // analog overcurrent counts only with the external pass transistor
    wire logic ana_oc_valid;
    assign ana_oc_valid = flt_rise[RCFF_F_ANA_OC] & ext_pass_transistor_i;

    // fault shutdown requests per rail
    // trips act on the rising edge only: a fault still high after a re-enable
    // does not trip again, so the host must watch the flags
    wire logic core_trip;
    wire logic ana_trip;
    wire logic aux_trip;
    assign core_trip = flt_rise[RCFF_F_CORE_OV];
    assign ana_trip = flt_rise[RCFF_F_ANA_OV] | ana_oc_valid;
    assign aux_trip = flt_rise[RCFF_F_AUX_OV] | flt_rise[RCFF_F_AUX_OC];

    // rail enables, one flop per rail: core, analog reference, auxiliary;
    // a trip beats a same-cycle on command for safety
    localparam int unsigned NRAIL = 3;
    wire logic [NRAIL-1:0] rail_trip;
    wire logic [NRAIL-1:0] rail_on;
    wire logic [NRAIL-1:0] rail_off;
    wire logic [NRAIL-1:0] rail_en;
    assign rail_trip = {aux_trip, ana_trip, core_trip};
    assign rail_on = {aux_on_i, ana_on_i, core_on_i};
    assign rail_off = {aux_off_i, ana_off_i, core_off_i};

    generate
        for (genvar g = 0; g < NRAIL; g++) begin : g_rail
            logic en_r;
            wire logic en_nxt;
            // on wins over off; only a command brings a tripped rail back
            assign en_nxt = rail_trip[g] ? 1'b0 :
                            (rail_on[g] ? 1'b1 : (rail_off[g] ? 1'b0 : en_r));
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    en_r <= 1'b1;
                end else if (clk_en_i) begin
                    en_r <= en_nxt;
                end
            end
            assign rail_en[g] = en_r;
        end
    endgenerate
    assign {auxiliary_rail_en_o, analog_reference_rail_en_o, core_supply_rail_en_o} = rail_en;
    // these two have no software control in this block
    assign preregulator_rail_en_o = 1'b1;
    assign transceiver_supply_rail_en_o = 1'b1;

    // sticky fault flags; a new event wins over a same-cycle clear
    logic [RCFF_NFLT-1:0] flag_r;
    logic [RCFF_NFLT-1:0] flag_set;
    assign flag_set = {flt_rise[RCFF_F_AUX_OC], flt_rise[RCFF_F_AUX_OV],
                       ana_oc_valid, flt_rise[RCFF_F_ANA_OV], flt_rise[RCFF_F_CORE_OV]};
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_r <= '0;
        end else if (clk_en_i) begin
            flag_r <= (flag_clr_i ? '0 : flag_r) | flag_set;
        end
    end
    // analog overvoltage shows in two status words, both from one flop
    assign core_ana_flags_o = {flag_r[RCFF_F_ANA_OV], flag_r[RCFF_F_CORE_OV]};
    assign ana_flags_o = {flag_r[RCFF_F_ANA_OC], flag_r[RCFF_F_ANA_OV]};
    assign aux_flags_o = {flag_r[RCFF_F_AUX_OC], flag_r[RCFF_F_AUX_OV]};

    // strap decode: open strap falls back to the lower voltage pair
    wire logic sel_50_50;
    wire logic sel_33_50;
    wire logic sel_50_33;
    wire logic [1:0] vp_dec;
    assign sel_50_50 = (sel_s == RCFF_SEL_50_50);
    assign sel_33_50 = (sel_s == RCFF_SEL_33_50);
    assign sel_50_33 = (sel_s == RCFF_SEL_50_33);
    // every code not named above, open strap included, gives 3.3/3.3
    assign vp_dec = sel_50_50 ? RCFF_VP_50_50 :
                    sel_33_50 ? RCFF_VP_33_50 :
                    sel_50_33 ? RCFF_VP_50_33 : RCFF_VP_33_33;

    // ground strap (code RCFF_SEL_33_33 only) enables deep fail-safe
    wire logic deep_dec;
    assign deep_dec = (sel_s == RCFF_SEL_33_33);

    // hardware configuration latch, reloaded only on a config read
    logic [1:0] vp_r;
    logic deep_main_r;
    logic deep_safe_r;
    logic buck_boost_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vp_r <= RCFF_VP_33_33;
            deep_main_r <= 1'b0;
            buck_boost_r <= 1'b0;
        end else if (clk_en_i && cfg_take) begin
            vp_r <= vp_dec;
            deep_main_r <= deep_dec;
            buck_boost_r <= gate_s;
        end
    end

    // fail-safe side reads the strap through its own synchroniser and edge
    // detect; a stuck flop in the main path cannot reach its copy
    logic [2:0] fs_sel1_r;
    logic [2:0] fs_sel2_r;
    logic fs_cfg1_r;
    logic fs_cfg2_r;
    logic fs_cfg_prev_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fs_sel1_r <= '0;
            fs_sel2_r <= '0;
            fs_cfg1_r <= 1'b0;
            fs_cfg2_r <= 1'b0;
            fs_cfg_prev_r <= 1'b0;
        end else if (clk_en_i) begin
            fs_sel1_r <= select_code_i;
            fs_sel2_r <= fs_sel1_r;
            fs_cfg1_r <= cfg_read_i;
            fs_cfg2_r <= fs_cfg1_r;
            fs_cfg_prev_r <= fs_cfg2_r;
        end
    end
    wire logic fs_cfg_take;
    wire logic fs_deep_dec;
    assign fs_cfg_take = fs_cfg2_r & ~fs_cfg_prev_r;
    assign fs_deep_dec = (fs_sel2_r == RCFF_SEL_33_33);

    // fail-safe copy kept in its own flop so one upset cannot hit both
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            deep_safe_r <= 1'b0;
        end else if (clk_en_i && fs_cfg_take) begin
            deep_safe_r <= fs_deep_dec;
        end
    end
    assign voltage_pair_o = vp_r;
    assign deep_fs_main_o = deep_main_r;
    assign deep_fs_safe_o = deep_safe_r;
    assign buck_boost_mode_o = buck_boost_r;

    // interrupt configuration, writable during init only
    // a write after init is dropped silently; the old setting stays in force
    logic int_long_r;
    logic int_en_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_long_r <= 1'b1;
            int_en_r <= 1'b1;
        end else if (clk_en_i && int_cfg_wr_i && init_phase_i) begin
            int_long_r <= int_cfg_long_i;
            int_en_r <= int_cfg_en_i;
        end
    end

    // pulse generator; an event during a pulse is queued behind it
    rcff_int_st_t int_st_r;
    rcff_int_st_t int_st_nxt;
    logic [RCFF_CNT_W-1:0] int_cnt_r;
    logic [RCFF_CNT_W-1:0] int_cnt_nxt;
    wire logic int_event;
    wire logic [RCFF_CNT_W-1:0] int_len;
    assign int_event = int_en_r & (|flag_set);
    assign int_len = int_long_r ? RCFF_CNT_W'(INT_LONG_CYC - 1) : RCFF_CNT_W'(INT_SHORT_CYC - 1);

    // an event inside a running pulse is kept and replayed once the pin has
    // been high for a cycle, so a condition is never lost; costs one flop
    logic int_pend_r;
    wire logic int_pend_nxt;
    wire logic int_go;
    assign int_pend_nxt = (int_st_r == RCFF_INT_PULSE) & (int_pend_r | int_event);
    assign int_go = int_event | int_pend_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_pend_r <= 1'b0;
        end else if (clk_en_i) begin
            int_pend_r <= int_pend_nxt;
        end
    end

    // next state and count of the pulse timer
    always_comb begin
        int_st_nxt = int_st_r;
        int_cnt_nxt = int_cnt_r;
        unique case (int_st_r)
            RCFF_INT_IDLE: begin
                if (int_go) begin
                    int_st_nxt = RCFF_INT_PULSE;
                    int_cnt_nxt = int_len;
                end
            end
            RCFF_INT_PULSE: begin
                if (int_cnt_r == '0) begin
                    int_st_nxt = RCFF_INT_IDLE;
                end else begin
                    int_cnt_nxt = int_cnt_r - 1'b1;
                end
            end
            default: begin
                int_st_nxt = RCFF_INT_IDLE;
                int_cnt_nxt = '0;
            end
        endcase
    end
    // timer state and count flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_st_r <= RCFF_INT_IDLE;
            int_cnt_r <= '0;
        end else if (clk_en_i) begin
            int_st_r <= int_st_nxt;
            int_cnt_r <= int_cnt_nxt;
        end
    end
    // pin driven from a flop so it cannot glitch between events
    logic int_n_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_n_r <= 1'b1;
        end else if (clk_en_i) begin
            int_n_r <= (int_st_nxt != RCFF_INT_PULSE);
        end
    end
    assign interrupt_pulse_out_n_o = int_n_r;
endmodule // rcff_regulator_control
`default_nettype wire

// >>> hdl/rcff_pkg.sv
// rcff_pkg: constants shared by the rail control and fault flag block.
// assumes a single 50 MHz clock domain.
package rcff_pkg;
    localparam int unsigned RCFF_CLK_HZ = 50_000_000;
    // interrupt pulse minimum widths in microseconds
    localparam int unsigned RCFF_INT_LONG_US = 90;
    localparam int unsigned RCFF_INT_SHORT_US = 20;
    // least times round up to whole cycles
    localparam int unsigned RCFF_INT_LONG_CYC = (RCFF_INT_LONG_US * (RCFF_CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned RCFF_INT_SHORT_CYC = (RCFF_INT_SHORT_US * (RCFF_CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned RCFF_CNT_W = 13;
    // strap decode codes (select pin comparator result)
    localparam logic [2:0] RCFF_SEL_33_33 = 3'h0;
    localparam logic [2:0] RCFF_SEL_50_50 = 3'h1;
    localparam logic [2:0] RCFF_SEL_33_50 = 3'h2;
    localparam logic [2:0] RCFF_SEL_50_33 = 3'h3;
    localparam logic [2:0] RCFF_SEL_OPEN = 3'h4;
    // latched voltage pair encoding, bit1 analog ref 5 V, bit0 aux 5 V
    localparam logic [1:0] RCFF_VP_33_33 = 2'h0;
    localparam logic [1:0] RCFF_VP_50_50 = 2'h3;
    localparam logic [1:0] RCFF_VP_33_50 = 2'h1;
    localparam logic [1:0] RCFF_VP_50_33 = 2'h2;
    // fault index positions
    localparam int unsigned RCFF_F_CORE_OV = 0;
    localparam int unsigned RCFF_F_ANA_OV = 1;
    localparam int unsigned RCFF_F_ANA_OC = 2;
    localparam int unsigned RCFF_F_AUX_OV = 3;
    localparam int unsigned RCFF_F_AUX_OC = 4;
    localparam int unsigned RCFF_NFLT = 5;
    typedef enum logic [1:0] {
        RCFF_INT_IDLE = 2'b01,
        RCFF_INT_PULSE = 2'b10
    } rcff_int_st_t;
endpackage : rcff_pkg

// >>> dv/rcff_regulator_control_chk.sv
// rcff_regulator_control_chk: port timing checks for rail control.
// assumes clk_en_i stays high while it watches.
`timescale 1ns/1ps
`default_nettype none
module rcff_regulator_control_chk #(
    parameter int unsigned INT_LONG_CYC = 8,
    parameter int unsigned INT_SHORT_CYC = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic core_ov_i,
    input wire logic aux_oc_i,
    input wire logic core_on_i,
    input wire logic core_off_i,
    input wire logic preregulator_rail_en_o,
    input wire logic core_supply_rail_en_o,
    input wire logic auxiliary_rail_en_o,
    input wire logic [1:0] core_ana_flags_o,
    input wire logic [1:0] aux_flags_o,
    input wire logic interrupt_pulse_out_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [7:0] low_r;
    // low time of the running pulse, zero while the pin is high
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) low_r <= 8'h00;
        else low_r <= interrupt_pulse_out_n_o ? 8'h00 : low_r + 8'h01;
    end
    // two sync flops plus edge detect, so allow up to four edges
    sequence s_trip(en, fl);
        ##[1:4] (!en && fl);
    endsequence
    a_prereg_on: assert property (preregulator_rail_en_o)
        else $error("prereg rail off");
    a_core_ov_trip: assert property ($rose(core_ov_i) |->
        s_trip(core_supply_rail_en_o, core_ana_flags_o[0])) else $error("core not tripped");
    a_aux_oc_trip: assert property ($rose(aux_oc_i) |->
        s_trip(auxiliary_rail_en_o, aux_flags_o[1])) else $error("aux not tripped");
    a_core_sw_on: assert property (core_on_i |=> core_supply_rail_en_o)
        else $error("core on ignored");
    a_core_sw_off: assert property (core_off_i && !core_on_i |=> !core_supply_rail_en_o)
        else $error("core off ignored");
    a_core_held_off: assert property (!core_supply_rail_en_o && !core_on_i |=>
        !core_supply_rail_en_o) else $error("core back on without command");
    a_int_width: assert property ($rose(interrupt_pulse_out_n_o) |->
        low_r == INT_LONG_CYC || low_r == INT_SHORT_CYC) else $error("bad pulse width");
    a_flag_int: assert property ($rose(core_ana_flags_o[0]) |-> !interrupt_pulse_out_n_o)
        else $error("flag without pulse");
endmodule // rcff_regulator_control_chk
`default_nettype wire

// >>> dv/rcff_host_model.sv
// rcff_host_model: host stand-in; serial writes arrive as strobes.
// assumes it shares the block's clock; counts interrupt pulses.
`timescale 1ns/1ps
`default_nettype none
module rcff_host_model (
    input wire logic clk_i,
    input wire logic interrupt_pulse_out_n_i,
    output logic core_on_o,
    output logic core_off_o,
    output logic ana_on_o,
    output logic ana_off_o,
    output logic aux_on_o,
    output logic aux_off_o,
    output logic flag_clr_o,
    output logic int_cfg_wr_o,
    output logic int_cfg_long_o,
    output logic int_cfg_en_o,
    output logic [7:0] pulses_o = 8'h00
);
    logic [9:0] s = 10'h000;
    assign {int_cfg_en_o, int_cfg_long_o, int_cfg_wr_o, flag_clr_o, aux_off_o, aux_on_o,
        ana_off_o, ana_on_o, core_off_o, core_on_o} = s;
    // each falling edge is one event seen by the host
    always @(negedge interrupt_pulse_out_n_i) pulses_o <= pulses_o + 8'h01;
    // rails here are not safety critical, so off commands are fair
    task automatic pulse(input logic [9:0] m);
        s = m;
        @(posedge clk_i);
        #1;
        s = 10'h000;
        // let one edge pass so back-to-back calls never retarget s at once
        @(posedge clk_i);
        #1;
    endtask
endmodule // rcff_host_model
`default_nettype wire

// >>> dv/rcff_regulator_control_tb.sv
// rcff_regulator_control_tb: directed run of the rail control block.
// assumes the host stand-in and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module rcff_regulator_control_tb;
    import rcff_pkg::*;
    localparam int unsigned SHORT_C = 4;
    localparam logic [1:0] VPX [5] = '{RCFF_VP_33_33, RCFF_VP_50_50, RCFF_VP_33_50,
        RCFF_VP_50_33, RCFF_VP_33_33};
    localparam int RIX [5] = '{0, 1, 1, 2, 2};
    logic clk_i = 1'b0, rst_n_i = 1'b0, cfg = 1'b0, bgs = 1'b0, ext = 1'b0, ini = 1'b1;
    logic [2:0] sel = 3'h0;
    logic [4:0] flt = 5'h00;
    wire logic c_on, c_off, a_on, a_off, x_on, x_off, f_clr, i_wr, i_lg, i_en;
    wire logic pre, xc, bb, dm, ds, int_n;
    wire logic [2:0] rails;
    wire logic [1:0] vp, caf, anf, axf;
    wire logic [7:0] pulses;
    wire logic [4:0] fls = {axf, anf[1], caf};
    int err_count = 0, n_tests = 0, cyc = 0, k = 0;
    always #10 clk_i = ~clk_i;
    rcff_regulator_control #(.INT_LONG_CYC(8), .INT_SHORT_CYC(SHORT_C)) u_rcff_regulator_control (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .cfg_read_i(cfg),
        .select_code_i(sel), .boost_gate_drive_sense_i(bgs), .ext_pass_transistor_i(ext),
        .core_ov_i(flt[0]), .ana_ov_i(flt[1]), .ana_oc_i(flt[2]), .aux_ov_i(flt[3]),
        .aux_oc_i(flt[4]), .core_on_i(c_on), .core_off_i(c_off), .ana_on_i(a_on),
        .ana_off_i(a_off), .aux_on_i(x_on), .aux_off_i(x_off), .flag_clr_i(f_clr),
        .init_phase_i(ini), .int_cfg_wr_i(i_wr), .int_cfg_long_i(i_lg), .int_cfg_en_i(i_en),
        .preregulator_rail_en_o(pre), .core_supply_rail_en_o(rails[0]),
        .analog_reference_rail_en_o(rails[1]), .auxiliary_rail_en_o(rails[2]),
        .transceiver_supply_rail_en_o(xc), .buck_boost_mode_o(bb), .voltage_pair_o(vp),
        .deep_fs_main_o(dm), .deep_fs_safe_o(ds), .core_ana_flags_o(caf), .ana_flags_o(anf),
        .aux_flags_o(axf), .interrupt_pulse_out_n_o(int_n));
    rcff_host_model u_host (.clk_i(clk_i), .interrupt_pulse_out_n_i(int_n), .core_on_o(c_on),
        .core_off_o(c_off), .ana_on_o(a_on), .ana_off_o(a_off), .aux_on_o(x_on),
        .aux_off_o(x_off), .flag_clr_o(f_clr), .int_cfg_wr_o(i_wr), .int_cfg_long_o(i_lg),
        .int_cfg_en_o(i_en), .pulses_o(pulses));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // runaway guard, far above the fewer than two hundred cycles the run needs
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        step(16);
        rst_n_i = 1'b1;
        step(1);
        chk("rails", 8'h1f, {3'h0, rails, pre, xc});
        $display("reset test done");
        // every strap code, then a strap move with no read that must not land
        for (int i = 0; i < 6; i++) begin
            sel = (i < 5) ? 3'(i) : 3'h1;
            bgs = sel[0];
            cfg = (i < 5);
            step(5);
            cfg = 1'b0;
            step(2);
            chk("pair", {6'h00, VPX[i < 5 ? i : 4]}, {6'h00, vp});
            chk("deep", {5'h00, i == 0, i == 0, i[0] && i < 5}, {5'h00, dm, ds, bb});
        end
        $display("config test done");
        // short width in init phase, later long request must bounce
        u_host.pulse(10'h280);
        ini = 1'b0;
        u_host.pulse(10'h380);
        ext = 1'b1;
        for (int f = 0; f < 5; f++) begin
            flt = 5'(1 << f);
            k = 0;
            while (int_n !== 1'b0 && k < 10) begin
                step(1);
                k++;
            end
            k = 0;
            while (int_n === 1'b0 && k < 20) begin
                step(1);
                k++;
            end
            chk("width", 8'(SHORT_C), 8'(k));
            chk("flag", 8'(1 << f), {3'h0, fls});
            chk("ana flags", 8'(((1 << f) >> 1) & 3), {6'h00, anf});
            chk("trip", 8'h00, {7'h00, rails[RIX[f]]});
            flt = 5'h00;
            step(6);
            chk("held", 8'h00, {7'h00, rails[RIX[f]]});
            u_host.pulse(10'(1 << (2 * RIX[f])));
            chk("reon", 8'h01, {7'h00, rails[RIX[f]]});
            u_host.pulse(10'h040);
        end
        ext = 1'b0;
        flt = 5'h04;
        step(8);
        chk("oc no ext", 8'h01, {7'h00, rails[1]});
        flt = 5'h00;
        for (int r = 0; r < 3; r++) begin
            u_host.pulse(10'(2 << (2 * r)));
            chk("sw off", 8'h00, {7'h00, rails[r]});
            u_host.pulse(10'(1 << (2 * r)));
            chk("sw on", 8'h01, {7'h00, rails[r]});
        end
        chk("pulses", 8'h05, pulses);
        $display("rail test done");
        print_verdict();
    end
endmodule // rcff_regulator_control_tb
bind rcff_regulator_control rcff_regulator_control_chk #(.INT_LONG_CYC(INT_LONG_CYC),
    .INT_SHORT_CYC(INT_SHORT_CYC)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .core_ov_i(core_ov_i), .aux_oc_i(aux_oc_i), .core_on_i(core_on_i), .core_off_i(core_off_i),
    .preregulator_rail_en_o(preregulator_rail_en_o), .core_supply_rail_en_o(core_supply_rail_en_o),
    .auxiliary_rail_en_o(auxiliary_rail_en_o), .core_ana_flags_o(core_ana_flags_o),
    .aux_flags_o(aux_flags_o), .interrupt_pulse_out_n_o(interrupt_pulse_out_n_o));
`default_nettype wire
